// ---- css_supervisor.v ----
// Combo supply supervisor: start-up sequencing, power-good, fault lock-out,
// skip, thermal gating and dead-time half-bridge pulse generation.
// Assumes comparator outputs arrive asynchronously on pins; one MCLK domain.
//
// Operation
// - Resonant stage waits 20 ms after boost ready
// - Restart clears the start-up delay counter
// - Power-good goes low after 20 ms
// - Bulk below good threshold releases power-good
// - Boost fault timer expiry stops resonant stage
// - First fault level restarts soft-start at maximum frequency
// - Second fault level latches whole controller off
// - Lock-out clears on undervoltage, brown-out, on/off toggle
// - Skip low suppresses resonant pulses when enabled
// - Dead time between half-bridge outputs
// - Over-temperature disables drive with hysteresis
// - Start switching at maximum frequency
// - Dead time typically 327 ns; rounded up here to 14 cycles, 350 ns at 40 MHz
// - Feedback undervoltage drops power-good, stops resonant stage
`include "css_map.vh"
`timescale 1ns/1ps
`default_nettype none

module css_supervisor #(
  parameter START_DELAY_CYC = `CSS_START_DELAY_CYC,
  parameter FAULT_STOP_CYC = `CSS_FAULT_STOP_CYC,
  parameter DEAD_CYC = `CSS_DEAD_TIME_CYC,
  parameter HALF_CYC = `CSS_HALF_PERIOD_CYC,
  parameter SKIP_VARIANT = 1
) (
  // Clock and reset
  input wire MCLK,
  input wire RESET,
  // Comparator and pin inputs
  input wire BOOST_STAGE_READY,
  input wire SUPPLY_UNDERVOLTAGE,
  input wire LINE_BROWN_OUT,
  input wire REMOTE_ON,
  input wire BULK_BELOW_GOOD,
  input wire BOOST_FAULT,
  input wire FEEDBACK_UNDERVOLTAGE,
  input wire FAULT_LEVEL1,
  input wire FAULT_LEVEL2,
  input wire REDUNDANT_OVERVOLTAGE_IN,
  input wire SKIP_IN,
  input wire OVER_TEMP,
  input wire TEMP_ABOVE_LOW,
  // Outputs
  output reg POWER_GOOD_N,
  output reg BOOST_ENABLE,
  output reg RESONANT_RUN,
  output reg SOFT_START_DISCHARGE,
  output reg HB_HIGH,
  output reg HB_LOW,
  output reg LOCKED_OUT
);

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  localparam NIN = 13;
  wire [NIN-1:0] raw_in;
  reg [NIN-1:0] sync1_reg;
  reg [NIN-1:0] sync2_reg;
  assign raw_in = {TEMP_ABOVE_LOW, OVER_TEMP, SKIP_IN, REDUNDANT_OVERVOLTAGE_IN,
                   FAULT_LEVEL2, FAULT_LEVEL1, FEEDBACK_UNDERVOLTAGE, BOOST_FAULT,
                   BULK_BELOW_GOOD, REMOTE_ON, LINE_BROWN_OUT, SUPPLY_UNDERVOLTAGE,
                   BOOST_STAGE_READY};

  // Two flip-flops per input bit
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1)
    begin : g_sync
      always @(posedge MCLK or posedge RESET)
      begin
        if (RESET)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end
        else
        begin
          sync1_reg[gi] <= raw_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  wire s_ready = sync2_reg[0];
  wire s_uv = sync2_reg[1];
  wire s_bo = sync2_reg[2];
  wire s_on = sync2_reg[3];
  wire s_bulk_low = sync2_reg[4];
  wire s_boost_fault = sync2_reg[5];
  wire s_fb_uv = sync2_reg[6];
  wire s_lvl1 = sync2_reg[7];
  wire s_lvl2 = sync2_reg[8];
  wire s_ovp = sync2_reg[9];
  wire s_skip = sync2_reg[10];
  wire s_hot = sync2_reg[11];
  wire s_warm = sync2_reg[12];

  // --------------------------------------------------------------------------
  // On/off edge, restart and lock-out
  // --------------------------------------------------------------------------
  reg on_prev_reg;
  reg lock_reg;
  reg hot_reg;
  wire on_toggle = s_on ^ on_prev_reg;
  wire restart = s_uv | s_bo | on_toggle;
  wire lock_set = s_lvl2 | s_ovp;

  // Lock-out latch; a new fault wins over a clear
  always @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      on_prev_reg <= 1'b0;
      lock_reg <= 1'b0;
    end
    else
    begin
      on_prev_reg <= s_on;
      if (lock_set)
        lock_reg <= 1'b1;
      else if (restart)
        lock_reg <= 1'b0;
    end
  end

  // Thermal hysteresis: set when hot, clear when below low threshold
  always @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
      hot_reg <= 1'b0;
    else if (s_hot)
      hot_reg <= 1'b1;
    else if (!s_warm)
      hot_reg <= 1'b0;
  end

  // Controller may run: on, supply good, no brown-out, not locked, not hot
  wire run_ok = s_on & ~s_uv & ~s_bo & ~lock_reg & ~lock_set & ~hot_reg;

  // --------------------------------------------------------------------------
  // Start-up delay and boost fault timer
  // --------------------------------------------------------------------------
  reg [31:0] start_cnt_reg;
  reg started_reg;
  reg [31:0] ftim_cnt_reg;
  reg fault_stop_reg;
  reg ftim_run_reg;

  // Start-up delay counts while boost is ready
  always @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      start_cnt_reg <= 32'h0;
      started_reg <= 1'b0;
    end
    else if (restart || !run_ok || !s_ready)
    begin
      start_cnt_reg <= 32'h0;
      started_reg <= 1'b0;
    end
    else if (!started_reg)
    begin
      if (start_cnt_reg == START_DELAY_CYC - 1)
        started_reg <= 1'b1;
      start_cnt_reg <= start_cnt_reg + 32'h1;
    end
  end

  // Boost fault timer, rearmed only by a restart or loss of run_ok; the fault need not clear first
  always @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      ftim_cnt_reg <= 32'h0;
      ftim_run_reg <= 1'b0;
      fault_stop_reg <= 1'b0;
    end
    else if (restart || !run_ok)
    begin
      ftim_cnt_reg <= 32'h0;
      ftim_run_reg <= 1'b0;
      fault_stop_reg <= 1'b0;
    end
    else if (s_boost_fault && !ftim_run_reg && !fault_stop_reg)
    begin
      ftim_run_reg <= 1'b1;
      ftim_cnt_reg <= 32'h0;
    end
    else if (ftim_run_reg)
    begin
      if (ftim_cnt_reg == FAULT_STOP_CYC - 1)
      begin
        ftim_run_reg <= 1'b0;
        fault_stop_reg <= 1'b1;
      end
      ftim_cnt_reg <= ftim_cnt_reg + 32'h1;
    end
  end

  wire boost_faulted = s_boost_fault | ftim_run_reg | fault_stop_reg;
  wire res_ok = run_ok & started_reg & ~fault_stop_reg & ~s_fb_uv;
  wire good = res_ok & ~s_bulk_low & ~boost_faulted;

  // --------------------------------------------------------------------------
  // Resonant oscillator with dead time
  // --------------------------------------------------------------------------
  localparam PH_IDLE = 2'b00;
  localparam PH_HIGH = 2'b01;
  localparam PH_DEAD = 2'b10;
  localparam PH_LOW = 2'b11;
  reg [1:0] ph_reg;
  reg [1:0] ph_next;
  reg [15:0] ph_cnt_reg;
  reg [15:0] ph_cnt_next;
  reg last_high_reg;
  reg last_high_next;
  wire pulse_ok = res_ok & ~(SKIP_VARIANT != 0 && !s_skip);

  // Phase sequencing: high, dead, low, dead
  always @*
  begin
    ph_next = ph_reg;
    ph_cnt_next = ph_cnt_reg + 16'h1;
    last_high_next = last_high_reg;
    case (ph_reg)
      PH_IDLE:
      begin
        ph_cnt_next = 16'h0;
        if (pulse_ok)
        begin
          ph_next = PH_DEAD;
          last_high_next = 1'b0;
        end
      end
      PH_HIGH:
        if (!pulse_ok || ph_cnt_reg == HALF_CYC[15:0] - 16'h1)
        begin
          ph_next = PH_DEAD;
          ph_cnt_next = 16'h0;
          last_high_next = 1'b1;
        end
      PH_DEAD:
        if (ph_cnt_reg >= DEAD_CYC[15:0] - 16'h1)
        begin
          ph_cnt_next = 16'h0;
          if (!pulse_ok)
            ph_next = PH_IDLE;
          else if (last_high_reg)
            ph_next = PH_LOW;
          else
            ph_next = PH_HIGH;
        end
      PH_LOW:
        if (!pulse_ok || ph_cnt_reg == HALF_CYC[15:0] - 16'h1)
        begin
          ph_next = PH_DEAD;
          ph_cnt_next = 16'h0;
          last_high_next = 1'b0;
        end
      default:
      begin
        ph_next = PH_IDLE;
        ph_cnt_next = 16'h0;
      end
    endcase
  end

  // Phase registers
  always @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      ph_reg <= PH_IDLE;
      ph_cnt_reg <= 16'h0;
      last_high_reg <= 1'b0;
    end
    else
    begin
      ph_reg <= ph_next;
      ph_cnt_reg <= ph_cnt_next;
      last_high_reg <= last_high_next;
    end
  end

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  always @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      POWER_GOOD_N <= 1'b1;
      BOOST_ENABLE <= 1'b0;
      RESONANT_RUN <= 1'b0;
      SOFT_START_DISCHARGE <= 1'b1;
      HB_HIGH <= 1'b0;
      HB_LOW <= 1'b0;
      LOCKED_OUT <= 1'b0;
    end
    else
    begin
      POWER_GOOD_N <= ~good;
      BOOST_ENABLE <= run_ok;
      RESONANT_RUN <= res_ok;
      SOFT_START_DISCHARGE <= ~res_ok | s_lvl1;
      HB_HIGH <= (ph_next == PH_HIGH) & pulse_ok;
      HB_LOW <= (ph_next == PH_LOW) & pulse_ok;
      LOCKED_OUT <= lock_reg | lock_set;
    end
  end

endmodule // css_supervisor
`default_nettype wire

// ---- css_map.vh ----
// Constants for the combo supply supervisor: clock rate, delays, dead time.
// Assumes a single 40 MHz clock; all times are converted to cycle counts here.
`ifndef CSS_MAP_VH
`define CSS_MAP_VH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define CSS_CLK_HZ 40000000

// ----------------------------------------------------------------------------
// Times in their own units and derived cycle counts
// ----------------------------------------------------------------------------
`define CSS_START_DELAY_MS 20
`define CSS_START_DELAY_CYC ((`CSS_START_DELAY_MS * (`CSS_CLK_HZ / 1000)))
`define CSS_FAULT_STOP_MS 5
`define CSS_FAULT_STOP_CYC ((`CSS_FAULT_STOP_MS * (`CSS_CLK_HZ / 1000)))
`define CSS_DEAD_TIME_NS 327
`define CSS_DEAD_TIME_CYC ((`CSS_DEAD_TIME_NS * (`CSS_CLK_HZ / 1000000) + 999) / 1000)
`define CSS_HALF_PERIOD_CYC 80

`endif

// ---- css_gate_drv.sv ----
// Half-bridge gate driver stand-in: counts high-side turn-on pulses.
// Assumes gate commands are registered on the same clock.
`timescale 1ns/1ps
`default_nettype none
module css_gate_drv (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Gate command
  input wire logic hb_high,
  // Count of high-side pulses
  output logic [15:0] hi_pulses
);
  logic hb_high_d;
  // Count rising edges of the high-side command
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      hb_high_d <= 1'b0;
      hi_pulses <= '0;
    end
    else
    begin
      hb_high_d <= hb_high;
      if (hb_high && !hb_high_d)
        hi_pulses <= hi_pulses + 16'h0001;
    end
endmodule // css_gate_drv
`default_nettype wire

// ---- css_supervisor_sva.sv ----
// Checker for css_supervisor, on its ports only.
// Assumes counts come through the bind from the design's parameters.
`timescale 1ns/1ps
`default_nettype none
module css_supervisor_sva #(
  parameter int START_DELAY_CYC = 800000,
  parameter int DEAD_CYC = 14,
  parameter int HALF_CYC = 80
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // Watched ports
  input wire logic BOOST_STAGE_READY,
  input wire logic REMOTE_ON,
  input wire logic BULK_BELOW_GOOD,
  input wire logic BOOST_FAULT,
  input wire logic FEEDBACK_UNDERVOLTAGE,
  input wire logic FAULT_LEVEL2,
  input wire logic REDUNDANT_OVERVOLTAGE_IN,
  input wire logic SKIP_IN,
  input wire logic POWER_GOOD_N,
  input wire logic RESONANT_RUN,
  input wire logic HB_HIGH,
  input wire logic HB_LOW,
  input wire logic LOCKED_OUT
);
  // ------------------------------------------------------------
  // Helper counters and assertions
  // ------------------------------------------------------------
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  logic [19:0] rdy_cnt_reg;
  logic [15:0] skip_cnt_reg;
  // Consecutive cycles of ready with remote on, and of skip held low
  always_ff @(posedge MCLK or posedge RESET)
    if (RESET)
    begin
      rdy_cnt_reg <= '0;
      skip_cnt_reg <= '0;
    end
    else
    begin
      rdy_cnt_reg <= (BOOST_STAGE_READY && REMOTE_ON) ? rdy_cnt_reg + 1'b1 : '0;
      skip_cnt_reg <= !SKIP_IN ? skip_cnt_reg + 1'b1 : '0;
    end
  a_start_delay: assert property (
    $rose(RESONANT_RUN) |-> rdy_cnt_reg >= START_DELAY_CYC) else $error("early start");
  a_bulk_drop: assert property (
    BULK_BELOW_GOOD [*4] |-> POWER_GOOD_N) else $error("good kept on low bulk");
  a_fault_drop: assert property (
    BOOST_FAULT [*4] |-> POWER_GOOD_N) else $error("good kept on boost fault");
  a_level2_lock: assert property (
    $rose(FAULT_LEVEL2) |-> ##[1:4] LOCKED_OUT) else $error("no lock on level two");
  a_ovp_lock: assert property (
    $rose(REDUNDANT_OVERVOLTAGE_IN) |-> ##[1:4] LOCKED_OUT) else $error("no lock on ovp");
  a_skip_idle: assert property (
    skip_cnt_reg > HALF_CYC + 2 * DEAD_CYC + 4 |-> !$rose(HB_HIGH)) else $error("pulse in skip");
  a_hb_apart: assert property (
    !(HB_HIGH && HB_LOW)) else $error("both gates on");
  a_dead_gap: assert property (
    $fell(HB_HIGH) |-> !HB_LOW [*8]) else $error("dead time short");
  a_fbuv_stop: assert property (
    FEEDBACK_UNDERVOLTAGE [*4] |-> POWER_GOOD_N && !RESONANT_RUN) else $error("uv not obeyed");
  a_reset_off: assert property (
    $fell(RESET) |-> POWER_GOOD_N && !RESONANT_RUN && !LOCKED_OUT) else $error("reset state");
endmodule // css_supervisor_sva
bind css_supervisor css_supervisor_sva #(
  .START_DELAY_CYC(START_DELAY_CYC), .DEAD_CYC(DEAD_CYC), .HALF_CYC(HALF_CYC)
) chk_u (
  .MCLK(MCLK), .RESET(RESET), .BOOST_STAGE_READY(BOOST_STAGE_READY),
  .REMOTE_ON(REMOTE_ON), .BULK_BELOW_GOOD(BULK_BELOW_GOOD), .BOOST_FAULT(BOOST_FAULT),
  .FEEDBACK_UNDERVOLTAGE(FEEDBACK_UNDERVOLTAGE), .FAULT_LEVEL2(FAULT_LEVEL2),
  .REDUNDANT_OVERVOLTAGE_IN(REDUNDANT_OVERVOLTAGE_IN), .SKIP_IN(SKIP_IN),
  .POWER_GOOD_N(POWER_GOOD_N), .RESONANT_RUN(RESONANT_RUN), .HB_HIGH(HB_HIGH),
  .HB_LOW(HB_LOW), .LOCKED_OUT(LOCKED_OUT)
);
`default_nettype wire

// ---- css_supervisor_test.sv ----
// Testbench for css_supervisor: one task a scenario, verdict at the end.
// Assumes the checker bind and the gate driver model are compiled.
`timescale 1ns/1ps
`default_nettype none
module css_supervisor_test;
  localparam int SD = 50;
  localparam int FS = 20;
  logic MCLK = 0, RESET = 1, rdy = 0, uv = 0, bo = 0, ron = 0, bulk = 0, bf = 0;
  logic fbuv = 0, f1 = 0, f2 = 0, ovp = 0, skip = 1, hot = 0, warm = 0;
  wire pg_n, ben, run, ssd, hbh, hbl, lock;
  wire [15:0] pulses;
  int error_cnt = 0, n_checks = 0, n;
  // Clock, 25 ns period
  always #12.5 MCLK = ~MCLK;
  css_supervisor #(.START_DELAY_CYC(SD), .FAULT_STOP_CYC(FS)) dut_u (
    .MCLK(MCLK), .RESET(RESET), .BOOST_STAGE_READY(rdy), .SUPPLY_UNDERVOLTAGE(uv),
    .LINE_BROWN_OUT(bo), .REMOTE_ON(ron), .BULK_BELOW_GOOD(bulk), .BOOST_FAULT(bf),
    .FEEDBACK_UNDERVOLTAGE(fbuv), .FAULT_LEVEL1(f1), .FAULT_LEVEL2(f2),
    .REDUNDANT_OVERVOLTAGE_IN(ovp), .SKIP_IN(skip), .OVER_TEMP(hot),
    .TEMP_ABOVE_LOW(warm), .POWER_GOOD_N(pg_n), .BOOST_ENABLE(ben), .RESONANT_RUN(run),
    .SOFT_START_DISCHARGE(ssd), .HB_HIGH(hbh), .HB_LOW(hbl), .LOCKED_OUT(lock));
  css_gate_drv drv_u (.clk(MCLK), .rst(RESET), .hb_high(hbh), .hi_pulses(pulses));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge MCLK);
    #1;
  endtask
  task automatic chk(input string nm, input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Waits, bounded, for the resonant stage to start
  task automatic start_up;
    n = 0;
    while (run !== 1'b1 && n < 4 * SD)
    begin
      cyc(1);
      n++;
    end
    cyc(1);
    chk("delay", n >= SD, 1'b1);
    chk("good", pg_n, 1'b0);
    if (n >= 4 * SD)
    begin
      error_cnt++;
      complete_run;
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_skip;
    @(posedge MCLK) skip <= 0;
    cyc(200);
    n = pulses;
    cyc(400);
    chk("skip", pulses == n, 1'b1);
    @(posedge MCLK) skip <= 1;
    cyc(400);
    chk("resume", pulses > n, 1'b1);
  endtask
  task automatic t_level1;
    @(posedge MCLK) f1 <= 1;
    cyc(6);
    chk("ssd", ssd, 1'b1);
    chk("run", run, 1'b1);
    @(posedge MCLK) f1 <= 0;
    cyc(6);
    chk("ssd off", ssd, 1'b0);
  endtask
  task automatic t_bulk;
    @(posedge MCLK) bulk <= 1;
    cyc(6);
    chk("bulk good", pg_n, 1'b1);
    chk("bulk run", run, 1'b1);
    @(posedge MCLK) bulk <= 0;
    cyc(6);
  endtask
  task automatic t_boost_fault;
    @(posedge MCLK) bf <= 1;
    cyc(6);
    chk("bf good", pg_n, 1'b1);
    chk("bf run", run, 1'b1);
    cyc(FS + 6);
    chk("bf stop", run, 1'b0);
    @(posedge MCLK) bf <= 0;
    @(posedge MCLK) ron <= 0;
    cyc(6);
    @(posedge MCLK) ron <= 1;
    start_up;
  endtask
  task automatic t_lock(input bit sel);
    @(posedge MCLK) if (sel) f2 <= 1; else ovp <= 1;
    cyc(6);
    @(posedge MCLK) if (sel) f2 <= 0; else ovp <= 0;
    cyc(6);
    chk("lock", lock, 1'b1);
    chk("lock run", run, 1'b0);
    chk("lock boost", ben, 1'b0);
    @(posedge MCLK) if (sel) uv <= 1; else bo <= 1;
    cyc(6);
    chk("unlock", lock, 1'b0);
    // Delay is timed from the release of the restart source
    @(posedge MCLK) if (sel) uv <= 0; else bo <= 0;
    start_up;
  endtask
  task automatic t_thermal;
    @(posedge MCLK) hot <= 1;
    @(posedge MCLK) warm <= 1;
    cyc(6);
    chk("hot run", run, 1'b0);
    @(posedge MCLK) hot <= 0;
    cyc(10);
    chk("hyst", run | hbh | hbl, 1'b0);
    @(posedge MCLK) warm <= 0;
    start_up;
  endtask
  task automatic t_fbuv;
    @(posedge MCLK) fbuv <= 1;
    cyc(6);
    chk("uv good", pg_n, 1'b1);
    chk("uv run", run, 1'b0);
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(posedge MCLK);
    RESET <= 0;
    cyc(1);
    chk("rst good", pg_n, 1'b1);
    chk("rst run", run | ben | lock | hbh, 1'b0);
    @(posedge MCLK) rdy <= 1;
    @(posedge MCLK) ron <= 1;
    start_up;
    t_skip;
    t_level1;
    t_bulk;
    t_boost_fault;
    t_lock(1);
    t_lock(0);
    t_thermal;
    t_fbuv;
    complete_run;
  end
endmodule // css_supervisor_test
`default_nettype wire
